// ==== src/adctr_top.sv ====
// Purpose: acquisition trigger front end with APB register access
// Assumes: 25 MHz clock, asynchronous active-high reset
// Notes: external and comparator pins are synchronised before use
//
// Summary of operation
// R01: software, external and analog trigger sources
// R02: polarity selects rising or falling edge
// R03: start write under software source triggers
// R04: strobe flag write makes a trigger event
// R05: external input edge of polarity triggers
// R06: comparator crossing in polarity direction triggers
// R07: three-bit field selects analog input channel
// R08: eight-bit threshold register drives the DAC
// R09: samples coded as 12-bit offset binary
// R10: full scale follows the channel gain
// R11: synchronise pins, one pulse per edge
// R12: select values above three are reserved
`timescale 1ns/1ps
module adctr_top import adctr_pkg::*; (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    // apb slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [9:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // trigger pins
    input wire logic EXTERNAL_TRIGGER_INPUT_IN,
    input wire logic ANALOG_COMPARE_IN,
    output logic [7:0] ANALOG_THRESHOLD_LEVEL_OUT,
    output logic [1:0] ANALOG_MUX_SEL_OUT,
    // trigger results
    output logic TRIGGER_EVENT_OUT,
    output logic ACQ_START_OUT,
    // sample path
    input wire logic [11:0] ADC_RAW_IN,
    input wire logic ADC_VALID_IN,
    input wire logic [1:0] ADC_CHAN_IN,
    output logic [11:0] SAMPLE_CODE_OUT,
    output logic [12:0] SAMPLE_FS_MV_OUT,
    output logic SAMPLE_VALID_OUT
);
    // register state
    logic polarity; // 1 selects falling edges
    adctr_src_t source; // active trigger source
    logic [2:0] analog_trigger_source_select; // comparator input pick
    logic [7:0] analog_threshold_level; // dac code
    logic [7:0] gains; // two bits per channel
    logic trig_seen; // sticky, write one clears
    logic [15:0] trig_count; // wraps silently
    logic trig_event;
    logic acq_start;
    logic [1:0] mux_sel;
    // bus response state
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // next values
    logic next_polarity;
    adctr_src_t next_source;
    logic [2:0] next_chan;
    logic [7:0] next_thresh;
    logic [7:0] next_gains;
    logic next_seen;
    logic [15:0] next_count;
    logic next_event;
    logic next_start;
    logic [1:0] next_mux_sel;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    // decode and strobes
    adctr_reg_t rd_sel;
    adctr_reg_t wr_sel;
    logic setup_phase;
    logic wr_done;
    logic soft_trigger_strobe;
    logic start_strobe;
    logic chan_valid;
    // synchronised pin views
    logic ext_level;
    logic ext_pulse;
    logic cmp_level;
    logic cmp_pulse;
    // coded sample view
    logic [11:0] code;
    logic [12:0] fs_mv;
    logic code_valid;

    // address to register, unmapped gives none
    function automatic adctr_reg_t decode(input logic [9:0] addr);
        case (addr)
            ADCTR_ADDR_CTRL: decode = ADCTR_REG_CTRL;
            ADCTR_ADDR_THRESH: decode = ADCTR_REG_THRESH;
            ADCTR_ADDR_STATUS: decode = ADCTR_REG_STATUS;
            ADCTR_ADDR_GAIN: decode = ADCTR_REG_GAIN;
            ADCTR_ADDR_SAMPLE: decode = ADCTR_REG_SAMPLE;
            default: decode = ADCTR_REG_NONE;
        endcase
    endfunction

    // external trigger pin, edge by polarity
    adctr_edge_sync u_ext_sync (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .async_in(EXTERNAL_TRIGGER_INPUT_IN),
        .falling_in(polarity),
        .level_out(ext_level),
        .pulse_out(ext_pulse)
    );

    // comparator high means signal above threshold
    adctr_edge_sync u_cmp_sync (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .async_in(ANALOG_COMPARE_IN),
        .falling_in(polarity),
        .level_out(cmp_level),
        .pulse_out(cmp_pulse)
    );

    // offset binary coder with gain-based full scale
    adctr_sample_coder u_coder (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .raw_in(ADC_RAW_IN),
        .valid_in(ADC_VALID_IN),
        .chan_in(ADC_CHAN_IN),
        .gains_in(gains),
        .code_out(code),
        .fs_mv_out(fs_mv),
        .valid_out(code_valid)
    );

    // bus phase decode and write strobes
    always_comb begin
        setup_phase = PSEL_IN & ~PENABLE_IN;
        wr_done = PSEL_IN & PENABLE_IN & PWRITE_IN & pready;
        rd_sel = decode(PADDR_IN);
        wr_sel = decode(PADDR_IN);
        soft_trigger_strobe = wr_done & (wr_sel == ADCTR_REG_CTRL)
            & PWDATA_IN[ADCTR_CTRL_STROBE_BIT]; // R04
        start_strobe = wr_done & (wr_sel == ADCTR_REG_CTRL)
            & PWDATA_IN[ADCTR_CTRL_START_BIT]; // R03
        chan_valid = analog_trigger_source_select <= ADCTR_CHAN_MAX; // R12
    end

    // register writes
    always_comb begin
        next_polarity = polarity;
        next_source = source;
        next_chan = analog_trigger_source_select;
        next_thresh = analog_threshold_level;
        next_gains = gains;
        if (wr_done) begin
            case (wr_sel)
                ADCTR_REG_CTRL: begin
                    next_polarity = PWDATA_IN[ADCTR_CTRL_POL_BIT]; // R02
                    next_source = adctr_src_t'(PWDATA_IN[ADCTR_CTRL_SRC_LSB +: 2]); // R01
                    next_chan = PWDATA_IN[ADCTR_CTRL_CHAN_LSB +: 3]; // R07
                end
                ADCTR_REG_THRESH: begin
                    next_thresh = PWDATA_IN[7:0]; // R08
                end
                ADCTR_REG_GAIN: begin
                    next_gains = PWDATA_IN[7:0]; // R10
                end
                default: begin
                    // status and sample writes only clear or are ignored
                end
            endcase
        end
    end

    // trigger source selection
    always_comb begin
        next_event = 1'b0;
        // the strobe is an internal edge already of the chosen polarity
        case (source)
            ADCTR_SRC_SOFT: begin
                next_event = soft_trigger_strobe | start_strobe; // R03 R04
            end
            ADCTR_SRC_EXT: begin
                next_event = ext_pulse | soft_trigger_strobe; // R05 R04
            end
            ADCTR_SRC_ANALOG: begin
                // reserved channel codes never fire
                next_event = (cmp_pulse & chan_valid) | soft_trigger_strobe; // R06 R12
            end
            default: begin
                next_event = soft_trigger_strobe; // R04
            end
        endcase
        next_start = start_strobe;
        next_mux_sel = chan_valid ? analog_trigger_source_select[1:0] : mux_sel; // R07 R12
    end

    // sticky seen flag and event count, set beats clear
    always_comb begin
        next_seen = trig_seen;
        next_count = trig_count;
        if (wr_done && (wr_sel == ADCTR_REG_STATUS) && PWDATA_IN[ADCTR_STAT_SEEN_BIT]) begin
            next_seen = 1'b0;
        end
        if (trig_event) begin
            next_seen = 1'b1;
            next_count = trig_count + 16'h0001;
        end
    end

    // read data and response prepared during setup
    always_comb begin
        next_pready = setup_phase;
        next_pslverr = 1'b0;
        next_prdata = ADCTR_RST_DATA;
        if (setup_phase) begin
            case (rd_sel)
                ADCTR_REG_CTRL: begin
                    // strobe and start bits read back as zero
                    next_prdata[ADCTR_CTRL_POL_BIT] = polarity;
                    next_prdata[ADCTR_CTRL_SRC_LSB +: 2] = source;
                    next_prdata[ADCTR_CTRL_CHAN_LSB +: 3] = analog_trigger_source_select; // R07
                end
                ADCTR_REG_THRESH: begin
                    next_prdata[7:0] = analog_threshold_level; // R08
                end
                ADCTR_REG_STATUS: begin
                    next_prdata[ADCTR_STAT_SEEN_BIT] = trig_seen;
                    next_prdata[ADCTR_STAT_EXT_BIT] = ext_level;
                    next_prdata[ADCTR_STAT_CMP_BIT] = cmp_level;
                    next_prdata[ADCTR_STAT_COUNT_LSB +: 16] = trig_count;
                end
                ADCTR_REG_GAIN: begin
                    next_prdata[7:0] = gains;
                end
                ADCTR_REG_SAMPLE: begin
                    next_prdata[11:0] = code; // R09
                    next_prdata[ADCTR_SAMPLE_FS_LSB +: 13] = fs_mv; // R10
                end
                default: begin
                    next_pslverr = 1'b1; // unmapped address
                end
            endcase
        end else begin
            // keep data stable through the access phase
            next_prdata = prdata;
            next_pslverr = 1'b0; // error stands with ready only
        end
    end

    // state registers
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            polarity <= ADCTR_RST_POL;
            source <= ADCTR_SRC_SOFT;
            analog_trigger_source_select <= ADCTR_RST_CHAN;
            analog_threshold_level <= ADCTR_RST_THRESH;
            gains <= ADCTR_RST_GAIN;
            trig_seen <= 1'b0;
            trig_count <= ADCTR_RST_COUNT;
            trig_event <= 1'b0;
            acq_start <= 1'b0;
            mux_sel <= 2'b00;
            prdata <= ADCTR_RST_DATA;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            polarity <= next_polarity;
            source <= next_source;
            analog_trigger_source_select <= next_chan;
            analog_threshold_level <= next_thresh;
            gains <= next_gains;
            trig_seen <= next_seen;
            trig_count <= next_count;
            trig_event <= next_event;
            acq_start <= next_start;
            mux_sel <= next_mux_sel;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // outputs straight from flops
    assign PRDATA_OUT = prdata;
    assign PREADY_OUT = pready;
    assign PSLVERR_OUT = pslverr;
    assign ANALOG_THRESHOLD_LEVEL_OUT = analog_threshold_level; // R08
    assign ANALOG_MUX_SEL_OUT = mux_sel;
    assign TRIGGER_EVENT_OUT = trig_event;
    assign ACQ_START_OUT = acq_start;
    assign SAMPLE_CODE_OUT = code;
    assign SAMPLE_FS_MV_OUT = fs_mv;
    assign SAMPLE_VALID_OUT = code_valid;
endmodule

// ==== src/adctr_pkg.sv ====
// Purpose: shared constants and types of the acquisition trigger front end
// Assumes: 32-bit APB data, one register per aligned word
// Notes: register index times four gives the byte address
package adctr_pkg;
    // register indices and byte addresses
    localparam logic [7:0] ADCTR_IDX_CTRL = 8'h0E;
    localparam logic [7:0] ADCTR_IDX_THRESH = 8'h24;
    localparam logic [7:0] ADCTR_IDX_STATUS = 8'h10;
    localparam logic [7:0] ADCTR_IDX_GAIN = 8'h11;
    localparam logic [7:0] ADCTR_IDX_SAMPLE = 8'h12;
    localparam logic [9:0] ADCTR_ADDR_CTRL = {ADCTR_IDX_CTRL, 2'b00};
    localparam logic [9:0] ADCTR_ADDR_THRESH = {ADCTR_IDX_THRESH, 2'b00};
    localparam logic [9:0] ADCTR_ADDR_STATUS = {ADCTR_IDX_STATUS, 2'b00};
    localparam logic [9:0] ADCTR_ADDR_GAIN = {ADCTR_IDX_GAIN, 2'b00};
    localparam logic [9:0] ADCTR_ADDR_SAMPLE = {ADCTR_IDX_SAMPLE, 2'b00};
    // control register fields
    localparam int ADCTR_CTRL_STROBE_BIT = 0;
    localparam int ADCTR_CTRL_POL_BIT = 1;
    localparam int ADCTR_CTRL_SRC_LSB = 2;
    localparam int ADCTR_CTRL_CHAN_LSB = 4;
    localparam int ADCTR_CTRL_START_BIT = 7;
    // status register fields
    localparam int ADCTR_STAT_SEEN_BIT = 0;
    localparam int ADCTR_STAT_EXT_BIT = 1;
    localparam int ADCTR_STAT_CMP_BIT = 2;
    localparam int ADCTR_STAT_COUNT_LSB = 16;
    // sample register fields
    localparam int ADCTR_SAMPLE_FS_LSB = 16;
    // reset values
    localparam logic ADCTR_RST_POL = 1'b0;
    localparam logic [2:0] ADCTR_RST_CHAN = 3'h0;
    localparam logic [7:0] ADCTR_RST_THRESH = 8'h80;
    localparam logic [7:0] ADCTR_RST_GAIN = 8'h00;
    localparam logic [15:0] ADCTR_RST_COUNT = 16'h0000;
    localparam logic [11:0] ADCTR_RST_CODE = 12'h000;
    localparam logic [31:0] ADCTR_RST_DATA = 32'h0000_0000;
    // highest valid analog source select value
    localparam logic [2:0] ADCTR_CHAN_MAX = 3'h3;
    // full-scale values in millivolts per gain step
    localparam logic [12:0] ADCTR_FS_GAIN1_MV = 13'd5000;
    localparam logic [12:0] ADCTR_FS_GAIN2_MV = 13'd2500;
    localparam logic [12:0] ADCTR_FS_GAIN5_MV = 13'd1000;
    localparam logic [12:0] ADCTR_FS_GAIN10_MV = 13'd500;

    // trigger source selection
    typedef enum logic [1:0] {
        ADCTR_SRC_SOFT = 2'b00,
        ADCTR_SRC_EXT = 2'b01,
        ADCTR_SRC_ANALOG = 2'b10,
        ADCTR_SRC_RSVD = 2'b11
    } adctr_src_t;

    // per-channel gain step
    typedef enum logic [1:0] {
        ADCTR_GAIN_1 = 2'b00,
        ADCTR_GAIN_2 = 2'b01,
        ADCTR_GAIN_5 = 2'b10,
        ADCTR_GAIN_10 = 2'b11
    } adctr_gain_t;

    // register decode result
    typedef enum logic [2:0] {
        ADCTR_REG_NONE,
        ADCTR_REG_CTRL,
        ADCTR_REG_THRESH,
        ADCTR_REG_STATUS,
        ADCTR_REG_GAIN,
        ADCTR_REG_SAMPLE
    } adctr_reg_t;
endpackage

// ==== src/adctr_edge_sync.sv ====
// Purpose: two-flop synchroniser with polarity-selected edge pulse
// Assumes: input is asynchronous to the clock
// Notes: pulse is one cycle per qualifying edge
`timescale 1ns/1ps
module adctr_edge_sync (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // async level and polarity, 1 selects falling
    input wire logic async_in,
    input wire logic falling_in,
    // synchronised level and edge pulse
    output logic level_out,
    output logic pulse_out
);
    logic meta; // first stage, read only by stage two
    logic sync; // second stage
    logic prev; // delayed copy for edge compare
    logic pulse;
    logic next_pulse;

    // edge compare on settled stages only
    always_comb begin
        if (falling_in) begin
            next_pulse = prev & ~sync; // R11
        end else begin
            next_pulse = ~prev & sync; // R11
        end
    end

    // register stages
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
            pulse <= 1'b0;
        end else begin
            meta <= async_in; // R11
            sync <= meta;
            prev <= sync;
            pulse <= next_pulse;
        end
    end

    assign level_out = sync;
    assign pulse_out = pulse;
endmodule

// ==== src/adctr_sample_coder.sv ====
// Purpose: converts signed converter samples to offset binary codes
// Assumes: raw sample is two's complement from same-clock logic
// Notes: full scale follows the gain of the sample's channel
`timescale 1ns/1ps
module adctr_sample_coder import adctr_pkg::*; (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // raw sample
    input wire logic [11:0] raw_in,
    input wire logic valid_in,
    input wire logic [1:0] chan_in,
    input wire logic [7:0] gains_in,
    // coded sample
    output logic [11:0] code_out,
    output logic [12:0] fs_mv_out,
    output logic valid_out
);
    logic [11:0] code;
    logic [12:0] fs_mv;
    logic valid;
    logic [11:0] next_code;
    logic [12:0] next_fs_mv;
    adctr_gain_t gain;

    // full scale per gain step
    function automatic logic [12:0] fs_of(input adctr_gain_t g);
        case (g)
            ADCTR_GAIN_1: fs_of = ADCTR_FS_GAIN1_MV; // R10
            ADCTR_GAIN_2: fs_of = ADCTR_FS_GAIN2_MV; // R10
            ADCTR_GAIN_5: fs_of = ADCTR_FS_GAIN5_MV; // R10
            default: fs_of = ADCTR_FS_GAIN10_MV; // R10
        endcase
    endfunction

    // flip sign bit: -FS to 000h, zero to 800h
    always_comb begin
        gain = adctr_gain_t'(gains_in[{chan_in, 1'b0} +: 2]);
        next_code = code;
        next_fs_mv = fs_mv;
        if (valid_in) begin
            next_code = {~raw_in[11], raw_in[10:0]}; // R09
            next_fs_mv = fs_of(gain); // R10
        end
    end

    // hold last coded sample
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            code <= ADCTR_RST_CODE;
            fs_mv <= ADCTR_FS_GAIN1_MV;
            valid <= 1'b0;
        end else begin
            code <= next_code;
            fs_mv <= next_fs_mv;
            valid <= valid_in;
        end
    end

    assign code_out = code;
    assign fs_mv_out = fs_mv;
    assign valid_out = valid;
endmodule

// ==== dv/adctr_chk.sv ====
// Purpose: port-level property checks of the trigger front end
// Assumes: one clock, asynchronous active-high reset
// Notes: ctrl fields are shadowed from committed apb writes
`timescale 1ns/1ps
module adctr_chk import adctr_pkg::*; (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    // apb
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [9:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    // trigger side
    input wire logic EXTERNAL_TRIGGER_INPUT_IN,
    input wire logic ANALOG_COMPARE_IN,
    input wire logic [7:0] ANALOG_THRESHOLD_LEVEL_OUT,
    input wire logic [1:0] ANALOG_MUX_SEL_OUT,
    input wire logic TRIGGER_EVENT_OUT,
    input wire logic ACQ_START_OUT,
    // sample side
    input wire logic [11:0] ADC_RAW_IN,
    input wire logic ADC_VALID_IN,
    input wire logic [11:0] SAMPLE_CODE_OUT,
    input wire logic SAMPLE_VALID_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    logic wr_commit; // write taken at this edge
    logic ctrl_wr; // write to the control register
    logic [5:0] cfg; // {chan, src, pol} as last written
    logic [5:0] next_cfg;
    assign wr_commit = PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT;
    assign ctrl_wr = wr_commit && (PADDR_IN == ADCTR_ADDR_CTRL);
    // shadow of source and polarity for pin checks
    always_comb begin
        next_cfg = ctrl_wr ? PWDATA_IN[6:1] : cfg;
    end
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            cfg <= 6'h00;
        end else begin
            cfg <= next_cfg;
        end
    end
    a_ready_after_setup: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
        else $error("no ready after setup");
    a_ready_in_access: assert property (PREADY_OUT |-> PSEL_IN && PENABLE_IN)
        else $error("ready outside access");
    a_err_with_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
        else $error("error without ready");
    a_strobe_makes_event: assert property (ctrl_wr && PWDATA_IN[0] |=> TRIGGER_EVENT_OUT)
        else $error("strobe gave no event");
    a_start_soft_only: assert property (ctrl_wr && PWDATA_IN[7] |=> ACQ_START_OUT
        && (TRIGGER_EVENT_OUT == ($past(cfg[2:1]) == ADCTR_SRC_SOFT || $past(PWDATA_IN[0]))))
        else $error("start pulse wrong");
    a_event_one_cycle: assert property (TRIGGER_EVENT_OUT |=> !TRIGGER_EVENT_OUT)
        else $error("event longer than a cycle");
    a_ext_edge_event: assert property (cfg[2:1] == ADCTR_SRC_EXT
        && (cfg[0] ? $fell(EXTERNAL_TRIGGER_INPUT_IN) : $rose(EXTERNAL_TRIGGER_INPUT_IN))
        |-> ##[1:8] TRIGGER_EVENT_OUT) else $error("pin edge missed");
    a_cmp_edge_event: assert property (cfg[2:1] == ADCTR_SRC_ANALOG && cfg[5:3] <= ADCTR_CHAN_MAX
        && (cfg[0] ? $fell(ANALOG_COMPARE_IN) : $rose(ANALOG_COMPARE_IN))
        |-> ##[1:8] TRIGGER_EVENT_OUT) else $error("crossing missed");
    a_dac_follows: assert property (wr_commit && PADDR_IN == ADCTR_ADDR_THRESH
        |=> ANALOG_THRESHOLD_LEVEL_OUT == $past(PWDATA_IN[7:0])) else $error("dac code wrong");
    a_mux_follows: assert property (ctrl_wr |-> ##2 ANALOG_MUX_SEL_OUT ==
        (($past(PWDATA_IN[6:4], 2) <= ADCTR_CHAN_MAX) ? $past(PWDATA_IN[5:4], 2)
        : $past(ANALOG_MUX_SEL_OUT, 2))) else $error("mux select wrong");
    a_code_offset: assert property (ADC_VALID_IN |=> SAMPLE_VALID_OUT
        && SAMPLE_CODE_OUT == $past(ADC_RAW_IN) + 12'h800) else $error("sample code wrong");
    c_strobe: cover property (ctrl_wr && PWDATA_IN[0]);
    c_ext: cover property (cfg[2:1] == ADCTR_SRC_EXT && TRIGGER_EVENT_OUT);
    c_cmp: cover property (cfg[2:1] == ADCTR_SRC_ANALOG && TRIGGER_EVENT_OUT);
endmodule
bind adctr_top adctr_chk u_chk (.*);

// ==== dv/adctr_pin_model.sv ====
// Purpose: far side model, trigger pin and threshold comparator
// Assumes: channel levels given in dac code units, one byte each
// Notes: one clock of comparator delay stands in for settling
`timescale 1ns/1ps
module adctr_pin_model (
    // clock
    input wire logic clk_in,
    // commanded pin and channel levels
    input wire logic ext_req_in,
    input wire logic [31:0] levels_in,
    // card outputs seen by the model
    input wire logic [7:0] thresh_in,
    input wire logic [1:0] sel_in,
    // pins into the card
    output logic ext_pin_out = 1'b0,
    output logic cmp_out = 1'b0
);
    logic next_ext; // ttl level to drive
    logic next_cmp; // selected input above threshold
    // pin follows the bench, comparator watches only the selected input
    always_comb begin
        next_ext = ext_req_in;
        next_cmp = levels_in[8 * sel_in +: 8] > thresh_in;
    end
    // change only on the card edge, like a slow source
    always @(posedge clk_in) begin
        ext_pin_out <= next_ext;
        cmp_out <= next_cmp;
    end
endmodule

// ==== dv/tb_adc_trigger_source_logic.sv ====
// Purpose: self-checking bench of the trigger front end
// Assumes: apb answers with no wait state but is waited for
// Notes: events are counted, checks run after a settle gap
`timescale 1ns/1ps
module tb_adc_trigger_source_logic import adctr_pkg::*;;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, ext_pin, cmp, trig, start, svalid;
    logic ext_req = 1'b0;
    logic [31:0] levels = 32'h0000_0000;
    logic [7:0] thresh;
    logic [1:0] mux_sel;
    logic [11:0] adc_raw = 12'h000;
    logic adc_valid = 1'b0;
    logic [1:0] adc_chan = 2'h0;
    logic [11:0] code;
    logic [12:0] fs_mv;
    int n_errors = 0;
    int samples_checked = 0;
    int n_trig = 0, n_start = 0, t_base = 0, s_base = 0, cycles = 0;
    adctr_top DUT (.CLK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .EXTERNAL_TRIGGER_INPUT_IN(ext_pin),
        .ANALOG_COMPARE_IN(cmp), .ANALOG_THRESHOLD_LEVEL_OUT(thresh), .ANALOG_MUX_SEL_OUT(mux_sel),
        .TRIGGER_EVENT_OUT(trig), .ACQ_START_OUT(start), .ADC_RAW_IN(adc_raw),
        .ADC_VALID_IN(adc_valid), .ADC_CHAN_IN(adc_chan), .SAMPLE_CODE_OUT(code),
        .SAMPLE_FS_MV_OUT(fs_mv), .SAMPLE_VALID_OUT(svalid));
    adctr_pin_model u_pins (.clk_in(clk), .ext_req_in(ext_req), .levels_in(levels),
        .thresh_in(thresh), .sel_in(mux_sel), .ext_pin_out(ext_pin), .cmp_out(cmp));
    initial begin
        forever #20 clk = ~clk;
    end
    // event counters and hang guard
    always @(posedge clk) begin
        n_trig += (trig === 1'b1);
        n_start += (start === 1'b1);
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input bit ok, input string msg);
        samples_checked++;
        if (!ok) begin
            n_errors++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    // one apb transfer, held until ready is seen
    task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
        chk(e === 1'b0, "write refused");
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk(q === x && e === xe, $sformatf("read %h got %h", a, q));
    endtask
    // compare event counts since last settle
    task automatic settle(input int dt, input int ds);
        repeat (12) @(posedge clk);
        chk(n_trig - t_base == dt && n_start - s_base == ds, "event count");
        t_base = n_trig;
        s_base = n_start;
    endtask
    task automatic bump(input int ch, input logic [7:0] hi);
        levels[8 * ch +: 8] <= hi;
        repeat (8) @(posedge clk);
        levels[8 * ch +: 8] <= 8'h00;
        repeat (8) @(posedge clk);
    endtask
    function automatic logic [31:0] ctl(input logic p, input logic [1:0] s, input logic [2:0] c,
        input logic stb, input logic go);
        return {24'h00_0000, go, c, s, p, stb};
    endfunction
    function automatic logic [12:0] fs_of(input logic [1:0] g);
        return g == 2'h0 ? 13'h1388 : g == 2'h1 ? 13'h09c4 : g == 2'h2 ? 13'h03e8 : 13'h01f4;
    endfunction
    initial begin
        logic [7:0] th;
        logic [11:0] r;
        int c;
        void'($urandom(32'h271d_f903));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk(thresh === 8'h80 && fs_mv === 13'h1388, "reset outputs");
        rd(ADCTR_ADDR_THRESH, 32'h0000_0080, 1'b0);
        rd(10'h3fc, 32'h0000_0000, 1'b1);
        th = 8'($urandom_range(32'h0000_00df, 32'h0000_0020));
        wr(ADCTR_ADDR_THRESH, {24'h00_0000, th});
        rd(ADCTR_ADDR_THRESH, {24'h00_0000, th}, 1'b0);
        chk(thresh === th, "dac code");
        settle(0, 0);
        for (int p = 0; p < 2; p++) begin
            wr(ADCTR_ADDR_CTRL, ctl(p[0], ADCTR_SRC_SOFT, 3'h0, 1'b1, 1'b0));
            settle(1, 0);
            rd(ADCTR_ADDR_CTRL, ctl(p[0], ADCTR_SRC_SOFT, 3'h0, 1'b0, 1'b0), 1'b0);
            wr(ADCTR_ADDR_CTRL, ctl(p[0], ADCTR_SRC_SOFT, 3'h0, 1'b0, 1'b1));
            settle(1, 1);
            ext_req <= 1'b1;
            repeat (8) @(posedge clk);
            ext_req <= 1'b0;
            settle(0, 0);
            wr(ADCTR_ADDR_CTRL, ctl(p[0], ADCTR_SRC_EXT, 3'h0, 1'b0, 1'b1));
            settle(1, 1);
            ext_req <= 1'b1;
            repeat (8) @(posedge clk);
            ext_req <= 1'b0;
            settle(1, 0);
            c = $urandom_range(3);
            wr(ADCTR_ADDR_CTRL, ctl(p[0], ADCTR_SRC_ANALOG, 3'(c), 1'b0, 1'b1));
            settle(0, 1);
            bump(c ^ 1, th + 8'h10);
            settle(0, 0);
            bump(c, th + 8'h10);
            settle(1, 0);
            wr(ADCTR_ADDR_CTRL, ctl(p[0], ADCTR_SRC_ANALOG, 3'h5, 1'b0, 1'b0));
            bump(c, th + 8'h10);
            settle(0, 0);
        end
        for (int g = 0; g < 4; g++) begin
            wr(ADCTR_ADDR_GAIN, {24'h00_0000, 2'(g + 3), 2'(g + 2), 2'(g + 1), 2'(g)});
            for (int ch = 0; ch < 4; ch++) begin
                r = ch == 0 ? 12'h800 : ch == 1 ? 12'h7ff : ch == 2 ? 12'h000 : 12'($urandom);
                @(posedge clk);
                adc_raw <= r;
                adc_chan <= 2'(ch);
                adc_valid <= 1'b1;
                @(posedge clk);
                adc_valid <= 1'b0;
                #1;
                chk(svalid === 1'b1 && code === r + 12'h800, "sample code");
                chk(fs_mv === fs_of(2'(g + ch)), "full scale");
            end
        end
        rd(ADCTR_ADDR_STATUS, {16'(n_trig), 16'h0001}, 1'b0);
        end_of_test();
    end
endmodule
